// ### hdl/servo_io_cond.sv
// Servo general-purpose I/O conditioning with APB configuration registers.
//
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "servo_io_params.svh"
module servo_io_cond (
  input  wire logic        CLK,
  input  wire logic        RST_B,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        DOG_PIN,
  input  wire logic        CLEAR_PIN,
  input  wire logic        STROKE_END_PIN,
  input  wire logic        RESET_PIN,
  input  wire logic        READY_IN,
  input  wire logic        HOME_DONE_IN,
  input  wire logic        WARNING_IN,
  input  wire logic        TROUBLE_IN,
  output logic             OUT_ASSIGN_THREE,
  output logic             WARNING_OUTPUT,
  output logic             TROUBLE_OUTPUT,
  output logic             DOG_DETECTED,
  output logic             DROOP_CLEAR,
  output logic             STROKE_STOP,
  output logic             STOP_SLOW,
  output logic             BASE_OFF,
  output logic             IRQ
);

  servo_io_pkg::apb_req_s req;
  logic [15:0] out3_sel_reg;
  logic [15:0] polarity_reg;
  logic [15:0] response_reg;
  logic [15:0] stop_sel_reg;
  logic [15:0] clear_sel_reg;
  logic [15:0] warn_sel_reg;
  logic [3:0]  irq_status_reg;
  logic [3:0]  irq_mask_reg;
  logic [`IN_COUNT-1:0] sync1_reg;
  logic [`IN_COUNT-1:0] sync2_reg;
  logic [`IN_COUNT-1:0] filt_reg;
  logic [`IN_COUNT-1:0] filt_prev_reg;
  logic [16:0] cnt_reg [`IN_COUNT];
  servo_io_pkg::filt_state_e state_reg [`IN_COUNT];

  assign req.addr  = PADDR;
  assign req.write = PWRITE;
  assign req.wdata = PWDATA;

  // Filter length in cycles for a response code; unknown codes fall back to no filtering.
  function automatic logic [16:0] filt_len(input logic [2:0] code);
    unique case (code)
      3'd1:    filt_len = 17'(`FILT_CYC(`FILT_US_1));
      3'd2:    filt_len = 17'(`FILT_CYC(`FILT_US_2));
      3'd3:    filt_len = 17'(`FILT_CYC(`FILT_US_3));
      3'd4:    filt_len = 17'(`FILT_CYC(`FILT_US_4));
      3'd5:    filt_len = 17'(`FILT_CYC(`FILT_US_5));
      default: filt_len = 17'h00000;
    endcase
  endfunction

  wire        wr_en     = PSEL & PENABLE & PWRITE & PREADY;
  // Read data is latched at setup so that it stands in the access cycle beside PREADY.
  wire        rd_en     = PSEL & ~PENABLE & ~PWRITE;
  wire [16:0] filt_cyc  = filt_len(response_reg[2:0]); // R4
  wire        addr_ok   = (req.addr <= `OFS_IN_STATE) && (req.addr[1:0] == 2'b00);
  wire        rising_clr = filt_reg[`IN_CLEAR] & ~filt_prev_reg[`IN_CLEAR];

  // Only the pin three code byte, response bits 2:0 and bits 0, 4 or 8 of the other settings matter; the manufacturer-only codes are left to software discipline.
  wire        dog_det   = polarity_reg[0] ? filt_reg[`IN_DOG] : ~filt_reg[`IN_DOG]; // R3
  wire        clr_pulse = clear_sel_reg[0] ? filt_reg[`IN_CLEAR] : rising_clr; // R5 R6
  wire        warn_mode = warn_sel_reg[4];
  wire        warn_next = WARNING_IN & ~warn_mode; // R7
  wire        trbl_next = TROUBLE_IN | (WARNING_IN & warn_mode); // R7
  wire        stroke_off = ~filt_reg[`IN_STROKE];
  wire        stop_slow_next = stop_sel_reg[4]; // R8
  wire        base_off_next = filt_reg[`IN_RESET] & ~stop_sel_reg[8]; // R8
  wire [3:0]  irq_event = {warn_next & ~WARNING_OUTPUT, stroke_off & ~STROKE_STOP,
                           rising_clr, dog_det & ~DOG_DETECTED};

  logic out3_next;
  always_comb begin
    unique case (out3_sel_reg[7:0]) // R1 R2
      `CODE_READY:     out3_next = READY_IN;
      `CODE_TROUBLE:   out3_next = trbl_next;
      `CODE_WARNING:   out3_next = warn_next;
      `CODE_HOME_DONE: out3_next = HOME_DONE_IN;
      default:         out3_next = 1'b0;
    endcase
  end

  logic [31:0] rdata_next;
  always_comb begin
    unique case (req.addr)
      `OFS_OUT3_SEL:   rdata_next = {16'h0000, out3_sel_reg};
      `OFS_POLARITY:   rdata_next = {16'h0000, polarity_reg};
      `OFS_RESPONSE:   rdata_next = {16'h0000, response_reg};
      `OFS_STOP_SEL:   rdata_next = {16'h0000, stop_sel_reg};
      `OFS_CLEAR_SEL:  rdata_next = {16'h0000, clear_sel_reg};
      `OFS_WARN_SEL:   rdata_next = {16'h0000, warn_sel_reg};
      `OFS_IRQ_STATUS: rdata_next = {28'h0000000, irq_status_reg};
      `OFS_IRQ_MASK:   rdata_next = {28'h0000000, irq_mask_reg};
      `OFS_IN_STATE:   rdata_next = {28'h0000000, filt_reg};
      default:         rdata_next = 32'h00000000;
    endcase
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      out3_sel_reg  <= `RST_OUT3_SEL; // R1
      polarity_reg  <= `RST_POLARITY;
      response_reg  <= `RST_RESPONSE;
      stop_sel_reg  <= `RST_STOP_SEL;
      clear_sel_reg <= `RST_CLEAR_SEL;
      warn_sel_reg  <= `RST_WARN_SEL;
      irq_mask_reg  <= 4'h0;
    end else if (wr_en) begin
      if (req.addr == `OFS_OUT3_SEL)  out3_sel_reg  <= req.wdata[15:0];
      if (req.addr == `OFS_POLARITY)  polarity_reg  <= req.wdata[15:0];
      if (req.addr == `OFS_RESPONSE)  response_reg  <= req.wdata[15:0];
      if (req.addr == `OFS_STOP_SEL)  stop_sel_reg  <= req.wdata[15:0];
      if (req.addr == `OFS_CLEAR_SEL) clear_sel_reg <= req.wdata[15:0];
      if (req.addr == `OFS_WARN_SEL)  warn_sel_reg  <= req.wdata[15:0];
      if (req.addr == `OFS_IRQ_MASK)  irq_mask_reg  <= req.wdata[3:0];
    end
  end

  // A new event wins over a write-one clear in the same cycle.
  wire [3:0] w1c = (wr_en && req.addr == `OFS_IRQ_STATUS) ? req.wdata[3:0] : 4'h0;
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      irq_status_reg <= 4'h0;
    end else begin
      irq_status_reg <= (irq_status_reg & ~w1c) | irq_event;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      PRDATA  <= 32'h00000000;
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      PRDATA  <= rd_en ? rdata_next : 32'h00000000;
      PREADY  <= PSEL & ~PENABLE;
      PSLVERR <= PSEL & ~PENABLE & ~addr_ok;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      sync1_reg     <= '0;
      sync2_reg     <= '0;
      filt_prev_reg <= '0;
    end else begin
      sync1_reg     <= {RESET_PIN, STROKE_END_PIN, CLEAR_PIN, DOG_PIN};
      sync2_reg     <= sync1_reg;
      filt_prev_reg <= filt_reg;
    end
  end

  // Each input owns a counter; a bounce restarts it, so short glitches never reach the level.
  for (genvar i = 0; i < `IN_COUNT; i++) begin : g_filt
    always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
        filt_reg[i]  <= 1'b0;
        cnt_reg[i]   <= 17'h00000;
        state_reg[i] <= servo_io_pkg::FILT_IDLE;
      end else begin
        unique case (state_reg[i])
          servo_io_pkg::FILT_IDLE: begin
            cnt_reg[i] <= 17'h00001;
            if (sync2_reg[i] != filt_reg[i]) begin
              if (filt_cyc <= 17'h00001) filt_reg[i] <= sync2_reg[i]; // R4
              else state_reg[i] <= servo_io_pkg::FILT_COUNT;
            end
          end
          servo_io_pkg::FILT_COUNT: begin
            if (sync2_reg[i] == filt_reg[i]) begin
              state_reg[i] <= servo_io_pkg::FILT_IDLE;
            end else if (cnt_reg[i] + 17'h00001 >= filt_cyc) begin
              filt_reg[i]  <= sync2_reg[i]; // R10
              state_reg[i] <= servo_io_pkg::FILT_IDLE;
            end else begin
              cnt_reg[i] <= cnt_reg[i] + 17'h00001;
            end
          end
          default: state_reg[i] <= servo_io_pkg::FILT_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      OUT_ASSIGN_THREE <= 1'b0;
      WARNING_OUTPUT   <= 1'b0;
      TROUBLE_OUTPUT   <= 1'b0;
      DOG_DETECTED     <= 1'b0;
      DROOP_CLEAR      <= 1'b0;
      STROKE_STOP      <= 1'b0;
      STOP_SLOW        <= 1'b0;
      BASE_OFF         <= 1'b0;
      IRQ              <= 1'b0;
    end else begin
      OUT_ASSIGN_THREE <= out3_next; // R1
      WARNING_OUTPUT   <= warn_next; // R7
      TROUBLE_OUTPUT   <= trbl_next; // R7
      DOG_DETECTED     <= dog_det; // R3
      DROOP_CLEAR      <= clr_pulse; // R5 R6
      STROKE_STOP      <= stroke_off; // R8
      STOP_SLOW        <= stop_slow_next; // R8
      BASE_OFF         <= base_off_next; // R8
      IRQ              <= |(irq_status_reg & irq_mask_reg);
    end
  end

  sequence s_clr_rise;
    $rose(filt_reg[`IN_CLEAR]);
  endsequence

  a_out3_home: assert property (@(posedge CLK) disable iff (!RST_B) // R1
    out3_sel_reg[7:0] == `CODE_HOME_DONE |=> OUT_ASSIGN_THREE == $past(HOME_DONE_IN))
    else $error("Pin three does not follow home done.");
  a_out3_off: assert property (@(posedge CLK) disable iff (!RST_B) // R2
    out3_sel_reg[7:0] == `CODE_ALWAYS_OFF |=> !OUT_ASSIGN_THREE)
    else $error("Pin three driven while always off.");
  a_dog_pol: assert property (@(posedge CLK) disable iff (!RST_B) // R3
    1'b1 |=> DOG_DETECTED == ($past(polarity_reg[0]) ~^ $past(filt_reg[`IN_DOG])))
    else $error("Dog detection polarity wrong.");
  a_clr_edge: assert property (@(posedge CLK) disable iff (!RST_B) // R5
    (clear_sel_reg[0] == 1'b0) throughout (s_clr_rise ##2 filt_reg[`IN_CLEAR]) |-> !DROOP_CLEAR)
    else $error("Edge clear lasted more than one cycle.");
  a_clr_level: assert property (@(posedge CLK) disable iff (!RST_B) // R6
    clear_sel_reg[0] && filt_reg[`IN_CLEAR] |=> DROOP_CLEAR)
    else $error("Level clear not held.");
  a_warn_combo: assert property (@(posedge CLK) disable iff (!RST_B) // R7
    WARNING_IN && !TROUBLE_IN |=> WARNING_OUTPUT != TROUBLE_OUTPUT)
    else $error("Warning outputs not one of two combinations.");
  a_base_off: assert property (@(posedge CLK) disable iff (!RST_B) // R8
    filt_reg[`IN_RESET] && !stop_sel_reg[8] |=> BASE_OFF)
    else $error("Base circuit not off during reset.");
  a_filt_hold: assert property (@(posedge CLK) disable iff (!RST_B) // R10
    $changed(filt_reg[`IN_DOG]) && response_reg[2:0] == 3'd1 |-> $past(sync2_reg[`IN_DOG]) == filt_reg[`IN_DOG])
    else $error("Filtered level changed without a steady pin.");

  // Bus handshake checks; a slave that answered late would stall every master on the bus.
  sequence s_apb_setup;
    PSEL && !PENABLE;
  endsequence

  sequence s_apb_access;
    PSEL && PENABLE && PREADY;
  endsequence

  a_ready_after_setup: assert property (@(posedge CLK) disable iff (!RST_B)
    s_apb_setup |=> PREADY)
    else $error("Ready missing after setup.");

  a_ready_one_cycle: assert property (@(posedge CLK) disable iff (!RST_B)
    PREADY |=> !PREADY)
    else $error("Ready stood longer than one cycle.");

  a_slverr_unmapped: assert property (@(posedge CLK) disable iff (!RST_B)
    PSEL && !PENABLE && !addr_ok |=> PSLVERR)
    else $error("Unmapped access not flagged.");

  a_rdata_idle: assert property (@(posedge CLK) disable iff (!RST_B)
    !PREADY |-> PRDATA == 32'h00000000)
    else $error("Read data shown outside the access cycle.");

  a_write_lands: assert property (@(posedge CLK) disable iff (!RST_B)
    s_apb_access ##0 (PWRITE && PADDR == `OFS_POLARITY) |=> polarity_reg == $past(PWDATA[15:0]))
    else $error("Register write did not land.");

  a_out3_ready: assert property (@(posedge CLK) disable iff (!RST_B) // R2
    out3_sel_reg[7:0] == `CODE_READY |=> OUT_ASSIGN_THREE == $past(READY_IN))
    else $error("Pin three does not follow ready.");

  a_out3_trouble: assert property (@(posedge CLK) disable iff (!RST_B) // R1
    out3_sel_reg[7:0] == `CODE_TROUBLE |=> OUT_ASSIGN_THREE == $past(TROUBLE_IN || (WARNING_IN && warn_sel_reg[4])))
    else $error("Pin three does not follow trouble.");

  a_out3_warning: assert property (@(posedge CLK) disable iff (!RST_B) // R1
    out3_sel_reg[7:0] == `CODE_WARNING |=> OUT_ASSIGN_THREE == $past(WARNING_IN && !warn_sel_reg[4]))
    else $error("Pin three does not follow warning.");

  a_out3_unknown: assert property (@(posedge CLK) disable iff (!RST_B) // R2
    !(out3_sel_reg[7:0] inside {`CODE_READY, `CODE_TROUBLE, `CODE_WARNING, `CODE_HOME_DONE}) |=> !OUT_ASSIGN_THREE)
    else $error("Pin three driven by an unsupported code.");

  a_stroke_stop: assert property (@(posedge CLK) disable iff (!RST_B) // R8
    1'b1 |=> STROKE_STOP == !$past(filt_reg[`IN_STROKE]))
    else $error("Stroke stop does not follow the stroke end input.");

  a_stop_style: assert property (@(posedge CLK) disable iff (!RST_B) // R8
    1'b1 |=> STOP_SLOW == $past(stop_sel_reg[4]))
    else $error("Stop style does not follow its setting.");

  a_base_kept: assert property (@(posedge CLK) disable iff (!RST_B) // R8
    stop_sel_reg[8] |=> !BASE_OFF)
    else $error("Base circuit turned off although kept on.");

  a_clr_quiet: assert property (@(posedge CLK) disable iff (!RST_B) // R5
    !clear_sel_reg[0] && !rising_clr |=> !DROOP_CLEAR)
    else $error("Edge clear without a rising edge.");

  a_clr_released: assert property (@(posedge CLK) disable iff (!RST_B) // R6
    clear_sel_reg[0] && !filt_reg[`IN_CLEAR] |=> !DROOP_CLEAR)
    else $error("Level clear held with the input off.");

  a_irq_level: assert property (@(posedge CLK) disable iff (!RST_B)
    1'b1 |=> IRQ == $past(|(irq_status_reg & irq_mask_reg)))
    else $error("Interrupt line does not follow enabled flags.");

  a_flag_sticky: assert property (@(posedge CLK) disable iff (!RST_B)
    irq_status_reg[0] && !w1c[0] |=> irq_status_reg[0])
    else $error("Event flag lost without a clear.");

  a_set_wins: assert property (@(posedge CLK) disable iff (!RST_B)
    irq_event[0] |=> irq_status_reg[0])
    else $error("Event lost against a clear.");

  a_filt_bypass: assert property (@(posedge CLK) disable iff (!RST_B) // R4
    state_reg[`IN_DOG] == servo_io_pkg::FILT_IDLE && filt_cyc <= 17'h00001 &&
    sync2_reg[`IN_DOG] != filt_reg[`IN_DOG] |=> filt_reg[`IN_DOG] == $past(sync2_reg[`IN_DOG]))
    else $error("Unfiltered input did not pass at once.");

  a_filt_waits: assert property (@(posedge CLK) disable iff (!RST_B) // R10
    state_reg[`IN_DOG] == servo_io_pkg::FILT_COUNT && cnt_reg[`IN_DOG] + 17'h00001 < filt_cyc
    |=> $stable(filt_reg[`IN_DOG]))
    else $error("Filtered level changed before the filter time.");

endmodule

// ### hdl/servo_io_params.svh
// Offsets, reset values, field positions and timing counts for the servo I/O conditioning block.
// Function
// R1: Output pin three carries the function chosen by its select code, default home done.
// R2: Code 24 home done, code 00 always off, code 02 ready.
// R3: Dog polarity bit clear: off means detected; set: on means detected.
// R4: Inputs filtered with selectable time 0 to 4.44 ms, default code 2.
// R5: Clear mode 0 discards droop pulses once at clear input rising edge.
// R6: Clear mode 1 discards droop pulses continuously while clear input is on.
// R7: Warning select picks one of two warning/trouble output combinations at warning.
// R8: Stop select picks stop style at stroke end and base state during reset.
// R9: Software must leave manufacturer settings at their initial values.
// R10: Filtered level changes only after raw pin held steady for filter time.
`ifndef SERVO_IO_PARAMS_SVH
`define SERVO_IO_PARAMS_SVH
`define OFS_OUT3_SEL     12'h000
`define OFS_POLARITY     12'h004
`define OFS_RESPONSE     12'h008
`define OFS_STOP_SEL     12'h00c
`define OFS_CLEAR_SEL    12'h010
`define OFS_WARN_SEL     12'h014
`define OFS_IRQ_STATUS   12'h018
`define OFS_IRQ_MASK     12'h01c
`define OFS_IN_STATE     12'h020
`define RST_OUT3_SEL     16'h0024
`define RST_POLARITY     16'h0000
`define RST_RESPONSE     16'h0002
`define RST_STOP_SEL     16'h0010
`define RST_CLEAR_SEL    16'h0000
`define RST_WARN_SEL     16'h0000
`define CODE_ALWAYS_OFF  8'h00
`define CODE_READY       8'h02
`define CODE_TROUBLE     8'h03
`define CODE_WARNING     8'h08
`define CODE_HOME_DONE   8'h24
`define CLK_HZ           25000000
`define FILT_US_1        880
`define FILT_US_2        1770
`define FILT_US_3        2660
`define FILT_US_4        3550
`define FILT_US_5        4440
`define FILT_CYC(us)     (((us) * (`CLK_HZ / 1000)) / 1000)
`define IN_DOG           0
`define IN_CLEAR         1
`define IN_STROKE        2
`define IN_RESET         3
`define IN_COUNT         4
`endif

// ### hdl/servo_io_pkg.sv
// Types shared by the servo I/O conditioning block.
package servo_io_pkg;
  typedef struct packed {
    logic [11:0] addr;
    logic        write;
    logic [31:0] wdata;
  } apb_req_s;
  typedef enum logic [1:0] {
    FILT_IDLE  = 2'b00,
    FILT_COUNT = 2'b01
  } filt_state_e;
endpackage

// ### test/servo_io_pins_model.sv
// Switches and sensors wired to the conditioned input pins.
`timescale 1ns/1ps
module servo_io_pins_model (
  input  wire logic       clk,
  output logic      [3:0] pin
);
  initial pin = 4'b0100;
  // A contact bounces b times before settling, so the filter sees real chatter.
  task automatic drive(input int i, input logic v, input int b);
    for (int k = 0; k <= 2 * b; k++) begin
      @(posedge clk);
      pin[i] <= (k % 2 == 0) ? v : ~v;
    end
  endtask
endmodule

// ### test/servo_io_signal_conditioning_tb.sv
// Self-checking bench for the servo I/O conditioning block.
`timescale 1ns/1ps
`include "servo_io_params.svh"
module servo_io_signal_conditioning_tb;
  logic        clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, rdy = 0, home = 0, wrn = 0, trb = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [3:0]  pin;
  logic        pready, pslverr, o3, wo, to, dd, dc, ss, sl, bo, irq, er;
  int          miscompares = 0, checks = 0, seed = 97523, hi, n;
  int          codes[$] = '{8'h00, 8'h02, 8'h03, 8'h08, 8'h24};
  always #20 clk = ~clk;
  servo_io_pins_model pins (.clk(clk), .pin(pin));
  servo_io_cond uut (.CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .DOG_PIN(pin[0]), .CLEAR_PIN(pin[1]), .STROKE_END_PIN(pin[2]), .RESET_PIN(pin[3]),
    .READY_IN(rdy), .HOME_DONE_IN(home), .WARNING_IN(wrn), .TROUBLE_IN(trb),
    .OUT_ASSIGN_THREE(o3), .WARNING_OUTPUT(wo), .TROUBLE_OUTPUT(to), .DOG_DETECTED(dd),
    .DROOP_CLEAR(dc), .STROKE_STOP(ss), .STOP_SLOW(sl), .BASE_OFF(bo), .IRQ(irq));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask
  task final_report;
    if (miscompares == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // The master never assumes a latency; only the watchdog ends a stuck wait.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [15:0] e);
    apb(0, a, 0);
    chk(rd, {16'h0000, e});
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  initial begin
    cyc(20);
    rst_b <= 1;
    rdc(`OFS_OUT3_SEL, `RST_OUT3_SEL);
    rdc(`OFS_POLARITY, `RST_POLARITY);
    rdc(`OFS_RESPONSE, `RST_RESPONSE);
    rdc(`OFS_STOP_SEL, `RST_STOP_SEL);
    rdc(`OFS_CLEAR_SEL, `RST_CLEAR_SEL);
    rdc(`OFS_WARN_SEL, `RST_WARN_SEL);
    apb(0, 12'h040, 0);
    chk(er, 1);
    apb(1, `OFS_RESPONSE, 0);
    foreach (codes[c]) begin
      apb(1, `OFS_OUT3_SEL, codes[c]);
      repeat (4) begin
        @(posedge clk);
        {rdy, home, trb, wrn} <= 4'($random(seed));
        cyc(3);
        chk(o3, codes[c] == 8'h02 ? rdy : codes[c] == 8'h03 ? trb : codes[c] == 8'h08 ? wrn :
            codes[c] == 8'h24 ? home : 1'b0);
      end
    end
    for (int p = 0; p < 2; p++) for (int l = 0; l < 2; l++) begin
      apb(1, `OFS_POLARITY, p);
      pins.drive(0, l, 0);
      cyc(8);
      chk(dd, l == p);
    end
    wrn <= 1;
    trb <= 0;
    for (int s = 0; s < 2; s++) begin
      apb(1, `OFS_WARN_SEL, s << 4);
      cyc(3);
      chk({wo, to}, s ? 2'b01 : 2'b10);
    end
    wrn <= 0;
    pins.drive(2, 0, 0);
    cyc(8);
    chk(ss, 1);
    pins.drive(2, 1, 0);
    for (int s = 0; s < 4; s++) begin
      apb(1, `OFS_STOP_SEL, {s[1], 3'h0, s[0], 4'h0});
      pins.drive(3, 1, 0);
      cyc(8);
      chk({ss, sl, bo}, {1'b0, s[0], ~s[1]});
      pins.drive(3, 0, 0);
    end
    for (int m = 0; m < 2; m++) begin
      apb(1, `OFS_CLEAR_SEL, m);
      hi = 0;
      pins.drive(1, 1, 0);
      for (n = 0; n < 10; n++) begin @(posedge clk); #1 hi += dc; end
      pins.drive(1, 0, 0);
      #1 hi += dc;
      for (n = 0; n < 10; n++) begin @(posedge clk); #1 hi += dc; end
      chk(hi, m ? 11 : 1);
    end
    // Event flags: an enabled dog event raises the line, a disabled one only the flag.
    apb(1, `OFS_POLARITY, 0);
    for (int k = 1; k >= 0; k--) begin
      apb(1, `OFS_IRQ_MASK, k);
      pins.drive(0, 1, 0);
      apb(1, `OFS_IRQ_STATUS, 32'h0000000f);
      cyc(2);
      chk(irq, 0);
      pins.drive(0, 0, 0);
      cyc(8);
      chk(irq, k);
      apb(0, `OFS_IRQ_STATUS, 0);
      chk(rd[0], 1);
      apb(1, `OFS_IRQ_STATUS, 1);
      cyc(2);
      chk(irq, 0);
    end
    apb(1, `OFS_RESPONSE, 1);
    pins.drive(0, 1, 5);
    cyc(21000);
    chk(dd, 1);
    cyc(1100);
    chk(dd, 0);
    final_report;
  end
  initial begin
    #(40 * 100000);
    miscompares++;
    final_report;
  end
endmodule
